// File: pbfs_pkg.sv
// Package for the port B pin function select block: field positions, reset values, role codes.
// Assumes one core clock domain; used only through pbfs_pkg::name.
package pbfs_pkg;
  // Port B pin indices (pin 3 does not exist)
  localparam int unsigned PIN_SDA = 0;
  localparam int unsigned PIN_EA = 1;
  localparam int unsigned PIN_AN5 = 2;
  localparam int unsigned PIN_SPD = 4;
  localparam int unsigned PIN_SPC = 5;
  // Pins that exist only on the larger package
  localparam logic [7:0] LARGE_ONLY_MASK = 8'hF0;
  // Pins that exist at all (bit 3 absent)
  localparam logic [7:0] PRESENT_MASK = 8'hF7;
  // Pins that offer a weak pull-up (pin 0 is open drain)
  localparam logic [7:0] PULLUP_CAP_MASK = 8'hF6;
  // Direction register reset: all inputs
  localparam logic [7:0] DIR_RESET = 8'hFF;
  // Converter channel numbers for pins 1, 2, 4, 5
  localparam logic [2:0] ADC_CH_PIN1 = 3'h4;
  localparam logic [2:0] ADC_CH_PIN2 = 3'h5;
  localparam logic [2:0] ADC_CH_PIN4 = 3'h6;
  localparam logic [2:0] ADC_CH_PIN5 = 3'h7;
  // Role field encodings
  localparam logic [2:0] ROLE_STANDALONE = 3'h0;
  localparam logic [2:0] ROLE_MO_MASTER = 3'h1;
  localparam logic [2:0] ROLE_MO_SLAVE = 3'h2;
  localparam logic [2:0] ROLE_MP_MASTER = 3'h3;
  localparam logic [2:0] ROLE_MP_SLAVE = 3'h4;
  // Drive strength codes on the driver control output
  localparam logic DRV_1A = 1'b1;
  localparam logic DRV_2A = 1'b0;
  typedef enum logic [1:0] {
    PBFS_ROLE_NONE,
    PBFS_ROLE_MASTER,
    PBFS_ROLE_SLAVE
  } pbfs_role_t;
endpackage

// File: pbfs_role_decode.sv
// Decodes the three-bit multiple-output role field into a role class.
// Assumes the field comes straight from the buffer control register bits.
`timescale 1ns/1ps
module pbfs_role_decode (
  input wire logic [2:0] i_role_field,
  output pbfs_pkg::pbfs_role_t o_role
);
  // Reserved codes fall back to standalone so no pin is stolen by accident
  always_comb begin
    if (i_role_field == pbfs_pkg::ROLE_MO_MASTER || i_role_field == pbfs_pkg::ROLE_MP_MASTER) begin
      o_role = pbfs_pkg::PBFS_ROLE_MASTER;
    end else if (i_role_field == pbfs_pkg::ROLE_MO_SLAVE || i_role_field == pbfs_pkg::ROLE_MP_SLAVE) begin
      o_role = pbfs_pkg::PBFS_ROLE_SLAVE;
    end else begin
      o_role = pbfs_pkg::PBFS_ROLE_NONE;
    end
  end
endmodule

// File: pbfs_ioc_detect.sv
// Change-of-state detector for port B pin levels.
// Assumes pin inputs already synchronous to the core clock.
`timescale 1ns/1ps
module pbfs_ioc_detect #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_level,
  input wire logic [WIDTH-1:0] i_enable,
  output logic [WIDTH-1:0] o_change
);
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] chg_q;
  logic [1:0] arm_q;
  // Previous level; a disabled pin reports nothing
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_q <= '0;
      chg_q <= '0;
      arm_q <= 2'h0;
    end else begin
      prev_q <= i_level;
      arm_q <= {arm_q[0], 1'b1};
      // Held off two cycles so a pulled-up pin does not report a false edge after reset
      chg_q <= (i_level ^ prev_q) & i_enable & {WIDTH{arm_q[1]}};
    end
  end
  assign o_change = chg_q;
endmodule

// File: pbfs_top.sv
// Port B pin function select: per-pin output driver muxing, analog routing, sense pull and drive controls.
// Assumes control bits arrive as plain synchronous ports from the core and pins resolve outside.
// Function
// - Pin 0 is an open-drain general purpose pin without weak pull-up, directed by the direction register, with change detect.
// - In I2C mode pin 0 is the I2C data line instead of a general purpose pin.
// - Pins 1, 2, 4, 5, 6, 7 are general purpose pins with direction, selectable weak pull-up and change detect.
// - Pin 1 reaches converter channel 4 only when its direction bit and analog select are both set.
// - Pin 2 reaches converter channel 5 only when its direction bit and analog select are both set.
// - Pin 4 reaches converter channel 6 only when its direction bit and analog select are both set.
// - Pin 5 reaches converter channel 7 only when its direction bit and analog select are both set.
// - In a master or slave role pin 1 carries the shared error amplifier, output on master and input on slave.
// - Pins 4 to 7 and their alternate functions exist only on the larger package.
// - On the larger package pin 4 also serves as serial programming data.
// - On the larger package pin 5 also serves as serial programming clock.
// - Pin 5 can be the alternate switching frequency synchronization input or output.
// - The sense pull-up bit connects the positive sense pull-up while set.
// - The sense pull-down bit connects the negative sense pull-down while set.
// - The drive strength bit selects 1A when set and 2A when clear for the high-side driver.
// - The master or slave role comes from a three-bit role field in the buffer control register.
`timescale 1ns/1ps
module pbfs_top #(
  parameter bit LARGE_PKG = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Control bits from the core
  input wire logic [7:0] i_port_b_direction_reg,
  input wire logic [7:0] i_port_b_latch,
  input wire logic [7:0] i_weak_pullup_en,
  input wire logic [7:0] i_ioc_en,
  input wire logic [3:0] i_analog_select,
  input wire logic i_i2c_enable,
  input wire logic i_sda_drive_low,
  input wire logic i_serial_prog_active,
  input wire logic i_serial_prog_data_out,
  input wire logic i_serial_prog_data_oe,
  input wire logic [2:0] i_multi_output_role_field,
  input wire logic i_alt_sync_select,
  input wire logic i_sync_clk_out,
  input wire logic i_sense_pos_pullup_enable,
  input wire logic i_sense_neg_pulldown_enable,
  input wire logic i_high_side_drive_strength,
  // Pins
  input wire logic [7:0] i_port_b_pin,
  output logic [7:0] o_port_b_pin_out,
  output logic [7:0] o_port_b_pin_oe,
  output logic [7:0] o_port_b_pullup_on,
  // Results toward the core and analog front end
  output logic [7:0] o_port_b_in,
  output logic [7:0] o_port_b_change,
  output logic o_sda_in,
  output logic o_serial_prog_data,
  output logic o_serial_prog_clock,
  output logic o_sync_clk_in,
  output logic o_err_amp_drive,
  output logic o_err_amp_sense,
  output logic [3:0] o_adc_route_en,
  output logic [2:0] o_adc_channel,
  output logic o_adc_channel_valid,
  output logic o_sense_pos_pullup,
  output logic o_sense_neg_pulldown,
  output logic o_high_side_drive_strength
);
  pbfs_pkg::pbfs_role_t role;
  logic [7:0] present;
  logic sync_own;
  logic [7:0] gp_out;
  logic [7:0] gp_oe;
  logic [7:0] out_d;
  logic [7:0] oe_d;
  logic [7:0] pu_d;
  logic [7:0] out_q;
  logic [7:0] oe_q;
  logic [7:0] pu_q;
  logic [7:0] in_q;
  logic [3:0] route_d;
  logic [3:0] route_q;
  logic [2:0] chan_q;
  logic chan_vld_q;
  logic [2:0] sense_q;
  logic sda_q;
  logic spd_q;
  logic spc_q;
  logic sync_in_q;
  logic ea_drv_q;
  logic ea_sense_q;

  // Role field decode
  pbfs_role_decode u_role (
    .i_role_field(i_multi_output_role_field),
    .o_role(role)
  );

  // Small package masks away pins 4 to 7 and everything behind them
  assign present = LARGE_PKG ? pbfs_pkg::PRESENT_MASK : (pbfs_pkg::PRESENT_MASK & ~pbfs_pkg::LARGE_ONLY_MASK);
  // Sync function needs an active role, the select bit and the pin to exist
  assign sync_own = i_alt_sync_select && (role != pbfs_pkg::PBFS_ROLE_NONE) && present[pbfs_pkg::PIN_SPC];

  // General purpose drivers; direction bit set means input
  always_comb begin
    gp_out = i_port_b_latch;
    gp_oe = ~i_port_b_direction_reg & present;
    // Open drain: only ever drives low, a high latch releases the pin
    gp_out[pbfs_pkg::PIN_SDA] = 1'b0;
    gp_oe[pbfs_pkg::PIN_SDA] = ~i_port_b_direction_reg[pbfs_pkg::PIN_SDA] & ~i_port_b_latch[pbfs_pkg::PIN_SDA];
  end

  // Peripheral overrides, applied after the general purpose drive
  always_comb begin
    out_d = gp_out;
    oe_d = gp_oe;
    if (i_i2c_enable) begin
      out_d[pbfs_pkg::PIN_SDA] = 1'b0;
      oe_d[pbfs_pkg::PIN_SDA] = i_sda_drive_low;
    end
    if (role == pbfs_pkg::PBFS_ROLE_MASTER) begin
      // Master hands its error amplifier out; the analog driver does the work
      oe_d[pbfs_pkg::PIN_EA] = 1'b0;
    end else if (role == pbfs_pkg::PBFS_ROLE_SLAVE) begin
      oe_d[pbfs_pkg::PIN_EA] = 1'b0;
    end
    if (i_serial_prog_active && present[pbfs_pkg::PIN_SPD]) begin
      out_d[pbfs_pkg::PIN_SPD] = i_serial_prog_data_out;
      oe_d[pbfs_pkg::PIN_SPD] = i_serial_prog_data_oe;
      oe_d[pbfs_pkg::PIN_SPC] = 1'b0;
    end else if (sync_own) begin
      out_d[pbfs_pkg::PIN_SPC] = i_sync_clk_out;
      oe_d[pbfs_pkg::PIN_SPC] = (role == pbfs_pkg::PBFS_ROLE_MASTER);
    end
  end

  // Weak pull-ups only where the pin offers one and is an input
  assign pu_d = i_weak_pullup_en & pbfs_pkg::PULLUP_CAP_MASK & present & ~oe_d;

  // Analog routing, one term per analog-capable pin
  localparam int unsigned AN_PIN [4] = '{pbfs_pkg::PIN_EA, pbfs_pkg::PIN_AN5, pbfs_pkg::PIN_SPD, pbfs_pkg::PIN_SPC};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_an
      assign route_d[g] = i_port_b_direction_reg[AN_PIN[g]] & i_analog_select[g] & present[AN_PIN[g]];
    end
  endgenerate

  // Pin drivers registered so the pads see no mux glitches
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      out_q <= 8'h00;
      oe_q <= 8'h00;
      pu_q <= 8'h00;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      pu_q <= pu_d;
    end
  end

  // Input capture; absent pins read zero
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      in_q <= 8'h00;
    end else begin
      in_q <= i_port_b_pin & present;
    end
  end

  // Analog routing and lowest-numbered active channel
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      route_q <= 4'h0;
      chan_q <= 3'h0;
      chan_vld_q <= 1'b0;
    end else begin
      route_q <= route_d;
      chan_vld_q <= |route_d;
      if (route_d[0]) begin
        chan_q <= pbfs_pkg::ADC_CH_PIN1;
      end else if (route_d[1]) begin
        chan_q <= pbfs_pkg::ADC_CH_PIN2;
      end else if (route_d[2]) begin
        chan_q <= pbfs_pkg::ADC_CH_PIN4;
      end else if (route_d[3]) begin
        chan_q <= pbfs_pkg::ADC_CH_PIN5;
      end else begin
        chan_q <= 3'h0;
      end
    end
  end

  // Peripheral inputs, zero whenever the function is not selected, except SDA which then reads one; slave sync input samples pin 5 even during serial programming
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sda_q <= 1'b1;
      spd_q <= 1'b0;
      spc_q <= 1'b0;
      sync_in_q <= 1'b0;
    end else begin
      sda_q <= i_i2c_enable ? i_port_b_pin[pbfs_pkg::PIN_SDA] : 1'b1;
      spd_q <= i_serial_prog_active & present[pbfs_pkg::PIN_SPD] & i_port_b_pin[pbfs_pkg::PIN_SPD];
      spc_q <= i_serial_prog_active & present[pbfs_pkg::PIN_SPC] & i_port_b_pin[pbfs_pkg::PIN_SPC];
      sync_in_q <= sync_own & (role == pbfs_pkg::PBFS_ROLE_SLAVE) & i_port_b_pin[pbfs_pkg::PIN_SPC];
    end
  end

  // Error amplifier switches: master drives the pin, slave senses it
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ea_drv_q <= 1'b0;
      ea_sense_q <= 1'b0;
    end else begin
      ea_drv_q <= (role == pbfs_pkg::PBFS_ROLE_MASTER);
      ea_sense_q <= (role == pbfs_pkg::PBFS_ROLE_SLAVE);
    end
  end

  // Sense pulls and drive strength; reset leaves pulls off and 2A drive
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sense_q <= {1'b0, 1'b0, pbfs_pkg::DRV_2A};
    end else begin
      sense_q[2] <= i_sense_pos_pullup_enable;
      sense_q[1] <= i_sense_neg_pulldown_enable;
      sense_q[0] <= i_high_side_drive_strength ? pbfs_pkg::DRV_1A : pbfs_pkg::DRV_2A;
    end
  end

  // Change detect on every present pin, open-drain pin included
  pbfs_ioc_detect #(
    .WIDTH(8)
  ) u_ioc (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_level(in_q),
    .i_enable(i_ioc_en & present),
    .o_change(o_port_b_change)
  );

  assign o_port_b_pin_out = out_q;
  assign o_port_b_pin_oe = oe_q;
  assign o_port_b_pullup_on = pu_q;
  assign o_port_b_in = in_q;
  assign o_sda_in = sda_q;
  assign o_serial_prog_data = spd_q;
  assign o_serial_prog_clock = spc_q;
  assign o_sync_clk_in = sync_in_q;
  assign o_err_amp_drive = ea_drv_q;
  assign o_err_amp_sense = ea_sense_q;
  assign o_adc_route_en = route_q;
  assign o_adc_channel = chan_q;
  assign o_adc_channel_valid = chan_vld_q;
  assign o_sense_pos_pullup = sense_q[2];
  assign o_sense_neg_pulldown = sense_q[1];
  assign o_high_side_drive_strength = sense_q[0];

  // Checks
  a_pin0_no_pullup: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !o_port_b_pullup_on[0]) else $error("pin 0 pull-up on");
  a_pin0_open_drain: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_port_b_pin_oe[0] |-> !o_port_b_pin_out[0]) else $error("pin 0 driven high");
  a_gpio_dir_out: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!i_port_b_direction_reg[2] && !i_i2c_enable) |=> o_port_b_pin_oe[2]) else $error("pin 2 not driven");
  a_an4_route: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_port_b_direction_reg[1] && i_analog_select[0]) |=> o_adc_route_en[0] && o_adc_channel == 3'h4)
    else $error("channel 4 not routed");
  a_an5_block: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !i_port_b_direction_reg[2] |=> !o_adc_route_en[1]) else $error("channel 5 routed on output");
  a_an6_route: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_adc_route_en[2] |-> $past(i_port_b_direction_reg[4] & i_analog_select[2])) else $error("channel 6 bad");
  a_an7_route: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_adc_route_en[3] |-> $past(i_port_b_direction_reg[5] & i_analog_select[3])) else $error("channel 7 bad");
  a_err_amp_role: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !(o_err_amp_drive && o_err_amp_sense)) else $error("error amp both ways");
  a_small_pkg: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !LARGE_PKG |-> (o_port_b_pin_oe[7:4] == 4'h0 && o_adc_route_en[3:2] == 2'h0)) else $error("absent pin used");
  a_sprog_data: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_serial_prog_active && LARGE_PKG) |=> o_port_b_pin_oe[4] == $past(i_serial_prog_data_oe))
    else $error("prog data not owning pin");
  a_sprog_clock: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_serial_prog_active |=> !o_port_b_pin_oe[5]) else $error("prog clock driven");
  a_sync_in_gate: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !sync_own |=> !o_sync_clk_in) else $error("sync in without ownership");
  a_sense_pulls: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ##1 (o_sense_pos_pullup == $past(i_sense_pos_pullup_enable)) && (o_sense_neg_pulldown == $past(i_sense_neg_pulldown_enable)))
    else $error("sense pull mismatch");
  a_drive_strength: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(i_high_side_drive_strength) |=> o_high_side_drive_strength) else $error("1A not selected");
  a_i2c_override: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_i2c_enable && !i_sda_drive_low) |=> !o_port_b_pin_oe[0]) else $error("sda held by gpio");
  c_i2c_low: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) i_i2c_enable ##1 o_port_b_pin_oe[0]);
  c_adc_route: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) o_adc_channel_valid && o_adc_channel == 3'h7);
  c_master: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) o_err_amp_drive && o_port_b_pin_oe[5]);
  c_sprog: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) i_serial_prog_active ##1 o_serial_prog_clock);
endmodule

// File: pbfs_board_model.sv
// Board side of port B: resolves each pin from the block drive, board drivers and pulls.
// Assumes one core clock; undriven pins without a pull are given a moving value.
`timescale 1ns/1ps
module pbfs_board_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe,
  input wire logic [7:0] i_pullup_on,
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_oe,
  output logic [7:0] o_pin_level
);
  logic [7:0] float_q = 8'h55;

  // Floating pins flip every cycle so a stale level never passes for a driven one
  always @(posedge i_clk_sys) begin
    float_q <= ~float_q;
  end

  // Block drive first, then board drivers, then pulls, else float
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (i_pin_oe[b]) begin
        o_pin_level[b] = i_pin_out[b];
      end else if (i_ext_oe[b]) begin
        o_pin_level[b] = i_ext_val[b];
      end else if (b == 0 || i_pullup_on[b]) begin
        o_pin_level[b] = 1'b1;
      end else begin
        o_pin_level[b] = float_q[b];
      end
    end
  end
endmodule

// File: port_b_pin_function_select_test.sv
// Self-checking bench for the port B pin function select block, large and small package.
// Assumes the board model file is compiled first; inputs change 2 ns after each rising edge.
`timescale 1ns/1ps
module port_b_pin_function_select_test;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] dir = pbfs_pkg::DIR_RESET, latch = 8'h00, wpu = 8'h00, ioc = 8'h00, ext_val = 8'h00, ext_oe = 8'h00;
  logic [3:0] ansel = 4'h0;
  logic i2c_en = 1'b0, sda_low = 1'b0, sp_act = 1'b0, sp_do = 1'b0, sp_oe = 1'b0;
  logic [2:0] role = pbfs_pkg::ROLE_STANDALONE;
  logic sync_sel = 1'b0, sync_out = 1'b0, spu = 1'b0, spd = 1'b0, drv = 1'b0;
  logic [7:0] pin, pout, poe, pup, pin_in, chg, s_oe, s_in;
  logic sda_in, sp_data, sp_clk, sync_in, ea_drive, ea_sense, ch_valid, sense_pu, sense_pd, hs_drv;
  logic [3:0] route, s_route;
  logic [2:0] chan;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [2:0] ch_tab [4] = '{pbfs_pkg::ADC_CH_PIN1, pbfs_pkg::ADC_CH_PIN2, pbfs_pkg::ADC_CH_PIN4, pbfs_pkg::ADC_CH_PIN5};
  int pin_tab [4] = '{1, 2, 4, 5};

  // 50 MHz core clock
  always #10 clk_sys = ~clk_sys;

  pbfs_top #(.LARGE_PKG(1'b1)) DUT (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_port_b_direction_reg(dir),
    .i_port_b_latch(latch), .i_weak_pullup_en(wpu), .i_ioc_en(ioc), .i_analog_select(ansel),
    .i_i2c_enable(i2c_en), .i_sda_drive_low(sda_low), .i_serial_prog_active(sp_act),
    .i_serial_prog_data_out(sp_do), .i_serial_prog_data_oe(sp_oe), .i_multi_output_role_field(role),
    .i_alt_sync_select(sync_sel), .i_sync_clk_out(sync_out), .i_sense_pos_pullup_enable(spu),
    .i_sense_neg_pulldown_enable(spd), .i_high_side_drive_strength(drv), .i_port_b_pin(pin),
    .o_port_b_pin_out(pout), .o_port_b_pin_oe(poe), .o_port_b_pullup_on(pup), .o_port_b_in(pin_in),
    .o_port_b_change(chg), .o_sda_in(sda_in), .o_serial_prog_data(sp_data), .o_serial_prog_clock(sp_clk),
    .o_sync_clk_in(sync_in), .o_err_amp_drive(ea_drive), .o_err_amp_sense(ea_sense), .o_adc_route_en(route),
    .o_adc_channel(chan), .o_adc_channel_valid(ch_valid), .o_sense_pos_pullup(sense_pu),
    .o_sense_neg_pulldown(sense_pd), .o_high_side_drive_strength(hs_drv));

  // Small package copy sees the same pins; only its upper pins are judged
  pbfs_top #(.LARGE_PKG(1'b0)) dut_small (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_port_b_direction_reg(dir),
    .i_port_b_latch(latch), .i_weak_pullup_en(wpu), .i_ioc_en(ioc), .i_analog_select(ansel),
    .i_i2c_enable(i2c_en), .i_sda_drive_low(sda_low), .i_serial_prog_active(sp_act),
    .i_serial_prog_data_out(sp_do), .i_serial_prog_data_oe(sp_oe), .i_multi_output_role_field(role),
    .i_alt_sync_select(sync_sel), .i_sync_clk_out(sync_out), .i_sense_pos_pullup_enable(spu),
    .i_sense_neg_pulldown_enable(spd), .i_high_side_drive_strength(drv), .i_port_b_pin(pin),
    .o_port_b_pin_out(), .o_port_b_pin_oe(s_oe), .o_port_b_pullup_on(), .o_port_b_in(s_in),
    .o_port_b_change(), .o_sda_in(), .o_serial_prog_data(), .o_serial_prog_clock(), .o_sync_clk_in(),
    .o_err_amp_drive(), .o_err_amp_sense(), .o_adc_route_en(s_route), .o_adc_channel(),
    .o_adc_channel_valid(), .o_sense_pos_pullup(), .o_sense_neg_pulldown(), .o_high_side_drive_strength());

  pbfs_board_model board (.i_clk_sys(clk_sys), .i_pin_out(pout), .i_pin_oe(poe), .i_pullup_on(pup),
    .i_ext_val(ext_val), .i_ext_oe(ext_oe), .o_pin_level(pin));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    chk(name, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard: the run is about 64 cycles
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    chk1("sda_in_reset", 1'b1, sda_in);
    chk1("drv_reset", pbfs_pkg::DRV_2A, hs_drv);
    #2 nrst = 1'b1;
    tick(1);
    $display("test reset done");
    spu = 1'b1; drv = 1'b1; tick(1);
    chk1("sense_pu", 1'b1, sense_pu);
    chk1("sense_pd", 1'b0, sense_pd);
    chk1("drv_str", pbfs_pkg::DRV_1A, hs_drv);
    spu = 1'b0; spd = 1'b1; drv = 1'b0; tick(1);
    chk1("sense_pu", 1'b0, sense_pu);
    chk1("sense_pd", 1'b1, sense_pd);
    chk1("drv_str", pbfs_pkg::DRV_2A, hs_drv);
    spd = 1'b0;
    $display("test sense_drive done");
    for (int k = 0; k < 4; k++) begin
      dir = pbfs_pkg::DIR_RESET; ansel = 4'h1 << k; tick(1);
      chk("adc_route", {4'h0, 4'h1 << k}, {4'h0, route});
      chk("adc_chan", {5'h00, ch_tab[k]}, {5'h00, chan});
      chk("small_route", 8'h00, {4'h0, s_route & 4'hC});
      dir = pbfs_pkg::DIR_RESET & ~(8'h01 << pin_tab[k]); tick(1);
      chk("adc_route_out", 8'h00, {4'h0, route});
    end
    dir = pbfs_pkg::DIR_RESET; ansel = 4'h6; tick(1);
    chk("adc_chan_two", {5'h00, pbfs_pkg::ADC_CH_PIN2}, {5'h00, chan});
    chk1("adc_valid", 1'b1, ch_valid);
    ansel = 4'h0; tick(1);
    chk1("adc_valid_off", 1'b0, ch_valid);
    $display("test analog done");
    dir = 8'h00; latch = 8'hA4; wpu = 8'hFF; tick(2);
    chk("gpio_oe", pbfs_pkg::PRESENT_MASK, poe);
    chk("gpio_out", 8'hA4, pout & poe);
    chk("gpio_in", 8'hA4, pin_in);
    chk("pullup_out", 8'h00, pup);
    chk("small_oe", 8'h00, s_oe & pbfs_pkg::LARGE_ONLY_MASK);
    latch = 8'hA5; tick(2);
    chk("od_release", 8'hF6, poe);
    chk("od_in", 8'hA5, pin_in);
    dir = pbfs_pkg::DIR_RESET; tick(1);
    chk("pullup_in", pbfs_pkg::PULLUP_CAP_MASK, pup);
    wpu = 8'h00; ext_oe = 8'h44; ioc = 8'h04; tick(3);
    ext_val = 8'h44; tick(2);
    chk("ioc_pulse", 8'h04, chg);
    chk("small_in", 8'h00, s_in & pbfs_pkg::LARGE_ONLY_MASK);
    tick(1);
    chk("ioc_clear", 8'h00, chg);
    ext_oe = 8'h00; ext_val = 8'h00; ioc = 8'h00;
    $display("test gpio done");
    dir = 8'hFE; latch = 8'h01; i2c_en = 1'b1; sda_low = 1'b1; tick(1);
    chk1("sda_oe", 1'b1, poe[0]);
    chk1("sda_out", 1'b0, pout[0]);
    dir = pbfs_pkg::DIR_RESET; sda_low = 1'b0; ext_oe = 8'h01; tick(2);
    chk1("sda_rel", 1'b0, poe[0]);
    chk1("sda_in_low", 1'b0, sda_in);
    ext_oe = 8'h00; tick(2);
    chk1("sda_in_high", 1'b1, sda_in);
    i2c_en = 1'b0;
    $display("test i2c done");
    for (int r = 0; r < 8; r++) begin
      dir = 8'h00; latch = 8'h00; role = r[2:0]; ext_oe = 8'h02; ext_val = 8'h02; tick(2);
      chk1("ea_drive", (r == 1 || r == 3), ea_drive);
      chk1("ea_sense", (r == 2 || r == 4), ea_sense);
      chk1("ea_pin_oe", !(r >= 1 && r <= 4), poe[1]);
    end
    dir = pbfs_pkg::DIR_RESET; role = pbfs_pkg::ROLE_STANDALONE; ext_oe = 8'h00; ext_val = 8'h00;
    $display("test role done");
    sp_act = 1'b1; sp_oe = 1'b1; sp_do = 1'b1; tick(1);
    chk1("prog_oe", 1'b1, poe[4]);
    chk1("prog_out", 1'b1, pout[4]);
    sp_oe = 1'b0; ext_oe = 8'h30; ext_val = 8'h20; tick(2);
    chk1("prog_data", 1'b0, sp_data);
    chk1("prog_clk", 1'b1, sp_clk);
    ext_val = 8'h10; tick(2);
    chk1("prog_data", 1'b1, sp_data);
    chk1("prog_clk", 1'b0, sp_clk);
    sp_act = 1'b0; sp_do = 1'b0; ext_oe = 8'h00;
    $display("test serial_prog done");
    role = pbfs_pkg::ROLE_MP_MASTER; sync_sel = 1'b1; sync_out = 1'b1; tick(1);
    chk1("sync_oe", 1'b1, poe[5]);
    chk1("sync_out", 1'b1, pout[5]);
    sync_out = 1'b0; tick(1);
    chk1("sync_out", 1'b0, pout[5]);
    role = pbfs_pkg::ROLE_MO_SLAVE; ext_oe = 8'h20; ext_val = 8'h20; tick(2);
    chk1("sync_slave_oe", 1'b0, poe[5]);
    chk1("sync_in", 1'b1, sync_in);
    ext_val = 8'h00; tick(2);
    chk1("sync_in", 1'b0, sync_in);
    $display("test sync done");
    stop_test();
  end
endmodule
